// ---- rtl/mmad_cfg.svh ----
`ifndef MMAD_CFG_SVH
`define MMAD_CFG_SVH

// ==========================================
// register indices
`define MMAD_REG_SYS_CFG 4'h0
`define MMAD_REG_PERIPH_CFG 4'h1
`define MMAD_REG_HIGH_WIN 4'h2
`define MMAD_REG_CTX_PTR 4'h3
`define MMAD_REG_IRQ_STATUS 4'h4
`define MMAD_REG_IRQ_MASK 4'h5
`define MMAD_REG_SEL_BASE 4'h6
`define MMAD_REG_LAST_TGT 4'hE

// ==========================================
// field positions
`define MMAD_SYS_GLOBAL_EN_BIT 2
`define MMAD_SYS_FLASH_MAP_BIT 4
`define MMAD_SYS_WMASK 16'h0014
`define MMAD_PER_CAN_A_BIT 0
`define MMAD_PER_CAN_B_BIT 1
`define MMAD_PER_LOW_RAM_BIT 2
`define MMAD_PER_HIGH_RAM_BIT 3
`define MMAD_PER_WMASK 16'h000F
`define MMAD_EVT_TRAP_BIT 0
`define MMAD_EVT_WIDTH_BIT 1
`define MMAD_EVT_EXT_BIT 2
`define MMAD_EVT_WMASK 16'h0007

// ==========================================
// reset values
`define MMAD_SYS_CFG_RST 16'h0010
`define MMAD_PERIPH_CFG_RST 16'h0000
`define MMAD_HIGH_WIN_RST 16'h0F09
`define MMAD_CTX_PTR_RST 16'hFC00

// ==========================================
// address map
`define MMAD_TEST_FLASH_END 24'h000FFF
`define MMAD_FLASH_LOW_END 24'h007FFF
`define MMAD_FLASH_S4_BASE 24'h018000
`define MMAD_FLASH_HIGH_END 24'h04FFFF
`define MMAD_RESV_SEG_LO 8'h05
`define MMAD_RESV_SEG_HI 8'h07
`define MMAD_FLASH_REG_SEG 8'h08
`define MMAD_INTERNAL_DUAL_PORT_RAM_LO 16'hF600
`define MMAD_INTERNAL_DUAL_PORT_RAM_HI 16'hFDFF
`define MMAD_SFR_LO 16'hFE00
`define MMAD_ESFR_LO 16'hF000
`define MMAD_ESFR_HI 16'hF1FF
`define MMAD_LOW_RAM_LO 16'hE000
`define MMAD_LOW_RAM_HI 16'hE7FF
`define MMAD_CAN_A_PAGE 8'hEF
`define MMAD_CAN_B_PAGE 8'hEE
`define MMAD_TRAP_VECTOR 16'h009B
`define MMAD_DUMMY_DATA 16'hFFFF

// ==========================================
// timing at the reference cpu clock
`define MMAD_REF_CLK_MHZ 40
`define MMAD_BASE_ACCESS_CYC 2
`define MMAD_XRAM_ACCESS_NS 50
`define MMAD_CAN_ACCESS_NS 100

`endif

// ---- rtl/mmad_pkg.sv ----
package mmad_pkg;

    // ==========================================
    // routing targets
    typedef enum logic [3:0] {
        MMAD_TGT_NONE = 4'b0000,
        MMAD_TGT_EXT = 4'b0001,
        MMAD_TGT_FLASH = 4'b0010,
        MMAD_TGT_TEST_FLASH = 4'b0011,
        MMAD_TGT_FLASH_REGS = 4'b0100,
        MMAD_TGT_RESERVED = 4'b0101,
        MMAD_TGT_INTERNAL_DUAL_PORT_RAM = 4'b0110,
        MMAD_TGT_SFR = 4'b0111,
        MMAD_TGT_XRAM_LOW = 4'b1000,
        MMAD_TGT_XRAM_HIGH = 4'b1001,
        MMAD_TGT_CAN_A = 4'b1010,
        MMAD_TGT_CAN_B = 4'b1011
    } mmad_target_e;

endpackage : mmad_pkg

// ---- rtl/mmad_decoder.sv ----
// Functional notes
// - one linear 16 Mbyte space holds code, data, registers and ports.
// - byte or word access everywhere, unless a target restricts width.
// - flash decodes as eight sectors plus a register block at 08'0000h.
// - test flash sits at 00'0000h in bootstrap mode only.
// - with flash mapping set, 05'0000h-07'FFFFh traps, no external cycle, dummy read.
// - internal dual port ram answers 00'F600h through 00'FDFFh.
// - register bank of 16 words, byte halves for the first eight.
// - extension rams use zero wait states, byte and word allowed.
// - low extension ram needs global and low enable bits.
// - otherwise low extension ram range goes external with matching bus set.
// - high extension ram answers in its window with global and high enable.
// - with global enable clear, high window goes external.
// - high window resets to 09'0000h-09'3FFFh, mirrored every 16K to 0F'FFFFh.
// - two 512 byte special function register areas.
// - first can window 00'EF00h-00'EFFFh needs global and its enable.
// - second can window 00'EE00h-00'EEFFh needs global and its enable.
// - can windows take words only, two wait states.
`include "mmad_cfg.svh"

module mmad_decoder #(
    parameter int ADDR_W = 24,
    parameter int NUM_SEL = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // mode strap
    input wire logic bootstrap_mode_i,
    // cpu access request
    input wire logic cpu_req_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_write_i,
    input wire logic cpu_byte_i,
    // routing answer
    output logic route_valid_o,
    output mmad_pkg::mmad_target_e route_target_o,
    output logic [ADDR_W-1:0] route_offset_o,
    output logic [2:0] route_sector_o,
    output logic [1:0] route_wait_states_o,
    output logic [2:0] ext_bus_set_o,
    output logic ext_launch_o,
    output logic gpr_hit_o,
    output logic [3:0] gpr_index_o,
    output logic gpr_byte_half_o,
    output logic width_error_o,
    output logic trap_o,
    output logic [15:0] trap_vector_o,
    output logic [15:0] dummy_rdata_o,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // interrupt
    output logic irq_o
);

    // ==========================================
    // wait states from access times at the reference clock
    localparam int XRAM_WAIT = (`MMAD_XRAM_ACCESS_NS * `MMAD_REF_CLK_MHZ + 999) / 1000
                               - `MMAD_BASE_ACCESS_CYC;
    localparam int CAN_WAIT = (`MMAD_CAN_ACCESS_NS * `MMAD_REF_CLK_MHZ + 999) / 1000
                              - `MMAD_BASE_ACCESS_CYC;
    localparam logic [1:0] XRAM_WS = 2'(XRAM_WAIT);
    localparam logic [1:0] CAN_WS = 2'(CAN_WAIT);

    // ==========================================
    // configuration registers
    logic [15:0] sys_cfg_q;
    logic [15:0] periph_cfg_q;
    logic [15:0] high_win_q;
    logic [15:0] ctx_ptr_q;
    logic [15:0] irq_status_q;
    logic [15:0] irq_mask_q;
    logic [15:0] sel_q [NUM_SEL];

    logic onchip_bus_global_enable;
    logic flash_map_enable;
    logic can_ctrl_a_enable;
    logic can_ctrl_b_enable;
    logic ext_ram_low_enable;
    logic ext_ram_high_enable;

    assign onchip_bus_global_enable = sys_cfg_q[`MMAD_SYS_GLOBAL_EN_BIT];
    assign flash_map_enable = sys_cfg_q[`MMAD_SYS_FLASH_MAP_BIT];
    assign can_ctrl_a_enable = periph_cfg_q[`MMAD_PER_CAN_A_BIT];
    assign can_ctrl_b_enable = periph_cfg_q[`MMAD_PER_CAN_B_BIT];
    assign ext_ram_low_enable = periph_cfg_q[`MMAD_PER_LOW_RAM_BIT];
    assign ext_ram_high_enable = periph_cfg_q[`MMAD_PER_HIGH_RAM_BIT];

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sys_cfg_q <= `MMAD_SYS_CFG_RST;
            periph_cfg_q <= `MMAD_PERIPH_CFG_RST;
            high_win_q <= `MMAD_HIGH_WIN_RST;
            ctx_ptr_q <= `MMAD_CTX_PTR_RST;
            irq_mask_q <= 16'h0000;
        end
        else if (reg_we_i)
        begin
            case (reg_addr_i)
                `MMAD_REG_SYS_CFG: sys_cfg_q <= reg_wdata_i & `MMAD_SYS_WMASK;
                `MMAD_REG_PERIPH_CFG: periph_cfg_q <= reg_wdata_i & `MMAD_PER_WMASK;
                `MMAD_REG_HIGH_WIN: high_win_q <= reg_wdata_i;
                `MMAD_REG_CTX_PTR: ctx_ptr_q <= {reg_wdata_i[15:1], 1'b0};
                `MMAD_REG_IRQ_MASK: irq_mask_q <= reg_wdata_i & `MMAD_EVT_WMASK;
                default: ;
            endcase
        end
    end

    // address select registers and their match
    logic [NUM_SEL-1:0] sel_match;

    for (genvar gi = 0; gi < NUM_SEL; gi++)
    begin : g_sel
        logic [11:0] win_mask;
        assign win_mask = 12'hFFF << sel_q[gi][3:0];
        always_ff @(posedge sys_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
                sel_q[gi] <= 16'h0000;
            else if (reg_we_i && reg_addr_i == 4'(`MMAD_REG_SEL_BASE + gi))
                sel_q[gi] <= reg_wdata_i;
        end
        // a select register left at zero is unused
        assign sel_match[gi] = (sel_q[gi] != 16'h0000) &&
                               (((cpu_addr_i[23:12] ^ sel_q[gi][15:4]) & win_mask) == 12'h000);
    end

    // lowest matching select wins; set 0 is the default
    logic [2:0] bus_set;
    always_comb
    begin
        bus_set = 3'h0;
        for (int i = NUM_SEL - 1; i >= 0; i--)
        begin
            if (sel_match[i])
                bus_set = 3'(i + 1);
        end
    end

    // ==========================================
    // address decode
    logic [7:0] seg;
    logic [15:0] low16;
    logic [7:0] page;
    logic [15:0] gpr_diff;
    mmad_pkg::mmad_target_e tgt;
    logic [ADDR_W-1:0] offs;
    logic [2:0] sector;
    logic [1:0] wait_st;
    logic width_err;
    logic resv_hit;
    logic high_win_hit;

    assign seg = cpu_addr_i[23:16];
    assign low16 = cpu_addr_i[15:0];
    assign page = cpu_addr_i[15:8];
    assign gpr_diff = low16 - ctx_ptr_q;
    // high window mirrors every 16K from first to last segment
    assign high_win_hit = (seg >= high_win_q[7:0]) && (seg <= high_win_q[15:8]);

    // fixed priority, first match wins
    always_comb
    begin
        tgt = mmad_pkg::MMAD_TGT_EXT;
        offs = cpu_addr_i;
        sector = 3'h0;
        wait_st = 2'h0;
        width_err = 1'b0;
        resv_hit = 1'b0;
        if (bootstrap_mode_i && cpu_addr_i <= `MMAD_TEST_FLASH_END)
        begin
            tgt = mmad_pkg::MMAD_TGT_TEST_FLASH;
            offs = {12'h000, cpu_addr_i[11:0]};
        end
        else if (flash_map_enable && (cpu_addr_i <= `MMAD_FLASH_LOW_END ||
                 (cpu_addr_i >= `MMAD_FLASH_S4_BASE && cpu_addr_i <= `MMAD_FLASH_HIGH_END)))
        begin
            tgt = mmad_pkg::MMAD_TGT_FLASH;
            if (seg == 8'h00)
                sector = {1'b0, cpu_addr_i[14:13]};
            else if (seg == 8'h01)
                sector = 3'h4;
            else
                sector = 3'(seg + 8'h03);
        end
        else if (flash_map_enable && seg >= `MMAD_RESV_SEG_LO && seg <= `MMAD_RESV_SEG_HI)
        begin
            tgt = mmad_pkg::MMAD_TGT_RESERVED;
            resv_hit = 1'b1;
        end
        else if (flash_map_enable && seg == `MMAD_FLASH_REG_SEG)
        begin
            tgt = mmad_pkg::MMAD_TGT_FLASH_REGS;
            offs = {8'h00, low16};
        end
        else if (seg == 8'h00 && low16 >= `MMAD_INTERNAL_DUAL_PORT_RAM_LO && low16 <= `MMAD_INTERNAL_DUAL_PORT_RAM_HI)
        begin
            tgt = mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM;
            offs = {8'h00, low16 - `MMAD_INTERNAL_DUAL_PORT_RAM_LO};
        end
        else if (seg == 8'h00 && (low16 >= `MMAD_SFR_LO ||
                 (low16 >= `MMAD_ESFR_LO && low16 <= `MMAD_ESFR_HI)))
        begin
            tgt = mmad_pkg::MMAD_TGT_SFR;
            offs = {14'h0000, low16[15:12] == 4'hF && low16[11:9] == 3'h7, low16[8:0]};
        end
        else if (seg == 8'h00 && low16 >= `MMAD_LOW_RAM_LO && low16 <= `MMAD_LOW_RAM_HI &&
                 onchip_bus_global_enable && ext_ram_low_enable)
        begin
            tgt = mmad_pkg::MMAD_TGT_XRAM_LOW;
            offs = {13'h0000, low16[10:0]};
            wait_st = XRAM_WS;
        end
        else if (seg == 8'h00 && (page == `MMAD_CAN_A_PAGE || page == `MMAD_CAN_B_PAGE) &&
                 onchip_bus_global_enable &&
                 (page == `MMAD_CAN_A_PAGE ? can_ctrl_a_enable : can_ctrl_b_enable))
        begin
            // refuse byte cycles rather than corrupt a neighbour byte
            if (cpu_byte_i)
            begin
                tgt = mmad_pkg::MMAD_TGT_NONE;
                width_err = 1'b1;
            end
            else
            begin
                tgt = (page == `MMAD_CAN_A_PAGE) ? mmad_pkg::MMAD_TGT_CAN_A
                                                 : mmad_pkg::MMAD_TGT_CAN_B;
                offs = {16'h0000, low16[7:0]};
                wait_st = CAN_WS;
            end
        end
        else if (high_win_hit && onchip_bus_global_enable && ext_ram_high_enable)
        begin
            tgt = mmad_pkg::MMAD_TGT_XRAM_HIGH;
            offs = {10'h000, cpu_addr_i[13:0]};
            wait_st = XRAM_WS;
        end
        // disabled windows fall through to external
    end

    // register bank inside internal ram
    logic gpr_hit;
    assign gpr_hit = (tgt == mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM) && (gpr_diff[15:5] == 11'h000);

    // ==========================================
    // routing answer, one cycle after the request
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            route_valid_o <= 1'b0;
            route_target_o <= mmad_pkg::MMAD_TGT_NONE;
            route_offset_o <= '0;
            route_sector_o <= 3'h0;
            route_wait_states_o <= 2'h0;
            ext_bus_set_o <= 3'h0;
            gpr_hit_o <= 1'b0;
            gpr_index_o <= 4'h0;
            gpr_byte_half_o <= 1'b0;
        end
        else
        begin
            route_valid_o <= cpu_req_i;
            if (cpu_req_i)
            begin
                route_target_o <= tgt;
                route_offset_o <= offs;
                route_sector_o <= sector;
                route_wait_states_o <= wait_st;
                ext_bus_set_o <= (tgt == mmad_pkg::MMAD_TGT_EXT) ? bus_set : 3'h0;
                gpr_hit_o <= gpr_hit;
                gpr_index_o <= gpr_diff[4:1];
                gpr_byte_half_o <= gpr_hit && cpu_byte_i && !gpr_diff[4];
            end
        end
    end

    // ==========================================
    // one-cycle strobes; trap vector and dummy read data hold their last value
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ext_launch_o <= 1'b0;
            trap_o <= 1'b0;
            width_error_o <= 1'b0;
            trap_vector_o <= 16'h0000;
            dummy_rdata_o <= 16'h0000;
        end
        else
        begin
            // a reserved hit never reaches the external bus
            ext_launch_o <= cpu_req_i && (tgt == mmad_pkg::MMAD_TGT_EXT);
            trap_o <= cpu_req_i && resv_hit;
            width_error_o <= cpu_req_i && width_err;
            if (cpu_req_i && resv_hit)
                trap_vector_o <= `MMAD_TRAP_VECTOR;
            if (cpu_req_i && resv_hit && !cpu_write_i)
                dummy_rdata_o <= `MMAD_DUMMY_DATA;
        end
    end

    // ==========================================
    // sticky flags; a new event beats a same-cycle clear
    logic [15:0] evt_set;
    logic [15:0] evt_clr;

    always_comb
    begin
        evt_set = 16'h0000;
        evt_set[`MMAD_EVT_TRAP_BIT] = cpu_req_i && resv_hit;
        evt_set[`MMAD_EVT_WIDTH_BIT] = cpu_req_i && width_err;
        evt_set[`MMAD_EVT_EXT_BIT] = cpu_req_i && (tgt == mmad_pkg::MMAD_TGT_EXT);
        evt_clr = (reg_we_i && reg_addr_i == `MMAD_REG_IRQ_STATUS) ? reg_wdata_i : 16'h0000;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            irq_status_q <= 16'h0000;
        else
            irq_status_q <= ((irq_status_q & ~evt_clr) | evt_set) & `MMAD_EVT_WMASK;
    end

    // level interrupt, rising with its flag
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(((irq_status_q & ~evt_clr) | evt_set) & irq_mask_q);
    end

    // ==========================================
    // read data one cycle after the strobe
    logic [15:0] rd_mux;

    always_comb
    begin
        rd_mux = 16'h0000;
        case (reg_addr_i)
            `MMAD_REG_SYS_CFG: rd_mux = sys_cfg_q;
            `MMAD_REG_PERIPH_CFG: rd_mux = periph_cfg_q;
            `MMAD_REG_HIGH_WIN: rd_mux = high_win_q;
            `MMAD_REG_CTX_PTR: rd_mux = ctx_ptr_q;
            `MMAD_REG_IRQ_STATUS: rd_mux = irq_status_q;
            `MMAD_REG_IRQ_MASK: rd_mux = irq_mask_q;
            `MMAD_REG_LAST_TGT: rd_mux = {12'h000, route_target_o};
            default:
            begin
                for (int i = 0; i < NUM_SEL; i++)
                begin
                    if (reg_addr_i == 4'(`MMAD_REG_SEL_BASE + i))
                        rd_mux = sel_q[i];
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_re_i)
            reg_rdata_o <= rd_mux;
        else
            reg_rdata_o <= 16'h0000;
    end

endmodule : mmad_decoder

// ---- tb/mmad_decoder_chk.sv ----
module mmad_decoder_chk #(
    parameter int ADDR_W = 24,
    parameter int NUM_SEL = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // request side
    input wire logic bootstrap_mode_i,
    input wire logic cpu_req_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_byte_i,
    input wire logic reg_re_i,
    // answer side
    input wire logic route_valid_o,
    input wire mmad_pkg::mmad_target_e route_target_o,
    input wire logic [1:0] route_wait_states_o,
    input wire logic ext_launch_o,
    input wire logic width_error_o,
    input wire logic trap_o,
    input wire logic [15:0] trap_vector_o,
    input wire logic [15:0] reg_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // ==========================================
    // routing
    resp_after_req_a: assert property (cpu_req_i |=> route_valid_o)
        else $error("no routing answer");
    no_stray_resp_a: assert property (!cpu_req_i |=> !route_valid_o)
        else $error("answer without request");
    ext_launch_a: assert property (ext_launch_o |-> route_valid_o && route_target_o == mmad_pkg::MMAD_TGT_EXT)
        else $error("launch for other target");
    trap_reserved_a: assert property (trap_o |-> route_target_o == mmad_pkg::MMAD_TGT_RESERVED
        && !ext_launch_o && trap_vector_o == 16'h009B)
        else $error("bad trap target or vector");
    internal_dual_port_ram_window_a: assert property (cpu_req_i && cpu_addr_i[23:16] == 8'h00 && cpu_addr_i[15:0] >= 16'hF600
        && cpu_addr_i[15:0] <= 16'hFDFF |=> route_target_o == mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM)
        else $error("internal ram window missed");
    test_flash_boot_a: assert property (route_valid_o && route_target_o == mmad_pkg::MMAD_TGT_TEST_FLASH
        |-> $past(bootstrap_mode_i))
        else $error("test flash outside bootstrap");
    can_byte_refused_a: assert property (cpu_req_i && cpu_byte_i && cpu_addr_i[23:9] == 15'h0077
        |=> route_target_o != mmad_pkg::MMAD_TGT_CAN_A && route_target_o != mmad_pkg::MMAD_TGT_CAN_B)
        else $error("byte access to can window");
    can_wait_a: assert property (route_valid_o && (route_target_o == mmad_pkg::MMAD_TGT_CAN_A
        || route_target_o == mmad_pkg::MMAD_TGT_CAN_B) |-> route_wait_states_o == 2'h2)
        else $error("can wait states wrong");
    xram_wait_a: assert property (route_valid_o && (route_target_o == mmad_pkg::MMAD_TGT_XRAM_LOW
        || route_target_o == mmad_pkg::MMAD_TGT_XRAM_HIGH) |-> route_wait_states_o == 2'h0)
        else $error("extension ram wait states");
    werr_pulse_a: assert property (width_error_o |-> route_target_o == mmad_pkg::MMAD_TGT_NONE
        ##1 !width_error_o || $past(cpu_req_i))
        else $error("width error with a target");
    rdata_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    cover property (trap_o);
    cover property (width_error_o);
endmodule : mmad_decoder_chk

bind mmad_decoder mmad_decoder_chk #(.ADDR_W(ADDR_W), .NUM_SEL(NUM_SEL)) mmad_decoder_chk_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bootstrap_mode_i(bootstrap_mode_i),
    .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_byte_i(cpu_byte_i), .reg_re_i(reg_re_i),
    .route_valid_o(route_valid_o), .route_target_o(route_target_o), .route_wait_states_o(route_wait_states_o),
    .ext_launch_o(ext_launch_o), .width_error_o(width_error_o), .trap_o(trap_o),
    .trap_vector_o(trap_vector_o), .reg_rdata_o(reg_rdata_o)
);

// ---- tb/mmad_cpu_model.sv ----
module mmad_cpu_model (
    // clock
    input wire logic sys_clk_i,
    // access request
    output logic cpu_req_o,
    output logic [23:0] cpu_addr_o,
    output logic cpu_write_o,
    output logic cpu_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cpu_req_o = 1'b0;
        cpu_addr_o = 24'h000000;
        cpu_write_o = 1'b0;
        cpu_byte_o = 1'b0;
    end

    // ==========================================
    // one byte or word access; no bit or stack use of extension ram
    task automatic access(input logic [23:0] addr, input logic wr, input logic byt);
        @(posedge sys_clk_i);
        cpu_req_o <= 1'b1;
        cpu_addr_o <= addr;
        cpu_write_o <= wr;
        cpu_byte_o <= byt;
        @(posedge sys_clk_i);
        cpu_req_o <= 1'b0;
        // released lines show garbage, not a stale address
        cpu_addr_o <= ~addr;
        cpu_write_o <= ~wr;
        cpu_byte_o <= ~byt;
    endtask : access
endmodule : mmad_cpu_model

// ---- tb/mmad_decoder_tb.sv ----
module mmad_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic bootstrap_mode_i = 1'b0;
    logic cpu_req, cpu_write, cpu_byte;
    logic [23:0] cpu_addr;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic route_valid_o, ext_launch_o, gpr_hit_o, gpr_byte_half_o, width_error_o, trap_o, irq_o;
    mmad_pkg::mmad_target_e route_target_o;
    logic [23:0] route_offset_o;
    logic [2:0] route_sector_o, ext_bus_set_o;
    logic [1:0] route_wait_states_o;
    logic [3:0] gpr_index_o;
    logic [15:0] trap_vector_o, dummy_rdata_o, reg_rdata_o;
    int bad_count = 0;
    int tests_run = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    mmad_cpu_model mmad_cpu_model_inst (.sys_clk_i(sys_clk_i), .cpu_req_o(cpu_req), .cpu_addr_o(cpu_addr),
        .cpu_write_o(cpu_write), .cpu_byte_o(cpu_byte));
    mmad_decoder mmad_decoder_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .bootstrap_mode_i(bootstrap_mode_i), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr),
        .cpu_write_i(cpu_write), .cpu_byte_i(cpu_byte), .route_valid_o(route_valid_o),
        .route_target_o(route_target_o), .route_offset_o(route_offset_o), .route_sector_o(route_sector_o),
        .route_wait_states_o(route_wait_states_o), .ext_bus_set_o(ext_bus_set_o), .ext_launch_o(ext_launch_o),
        .gpr_hit_o(gpr_hit_o), .gpr_index_o(gpr_index_o), .gpr_byte_half_o(gpr_byte_half_o),
        .width_error_o(width_error_o), .trap_o(trap_o), .trap_vector_o(trap_vector_o),
        .dummy_rdata_o(dummy_rdata_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

    // ==========================================
    // shared helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_we_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_re_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask : rd

    // read access; target checked while the strobes stand
    task automatic go(input logic [23:0] a, input logic byt, input mmad_pkg::mmad_target_e tgt);
        mmad_cpu_model_inst.access(a, 1'b0, byt);
        #1;
        chk(route_target_o, tgt);
    endtask : go

    // ==========================================
    // scenarios
    task automatic t_reset;
        rd(4'h0, 16'h0010);
        rd(4'h2, 16'h0F09);
        rd(4'hF, 16'h0000);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_flash;
        go(24'h000000, 1'b0, mmad_pkg::MMAD_TGT_FLASH);
        chk(route_sector_o, 3'h0);
        go(24'h007FFF, 1'b1, mmad_pkg::MMAD_TGT_FLASH);
        chk(route_sector_o, 3'h3);
        go(24'h018000, 1'b0, mmad_pkg::MMAD_TGT_FLASH);
        chk(route_sector_o, 3'h4);
        go(24'h04FFFF, 1'b0, mmad_pkg::MMAD_TGT_FLASH);
        chk(route_sector_o, 3'h7);
        go(24'h080000, 1'b0, mmad_pkg::MMAD_TGT_FLASH_REGS);
        go(24'h008000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        chk(ext_launch_o, 1'b1);
        @(posedge sys_clk_i) bootstrap_mode_i <= 1'b1;
        go(24'h000000, 1'b0, mmad_pkg::MMAD_TGT_TEST_FLASH);
        go(24'h001000, 1'b0, mmad_pkg::MMAD_TGT_FLASH);
        @(posedge sys_clk_i) bootstrap_mode_i <= 1'b0;
        go(24'h000FFF, 1'b0, mmad_pkg::MMAD_TGT_FLASH);
        $display("t_flash done");
    endtask : t_flash

    task automatic t_reserved;
        go(24'h050000, 1'b0, mmad_pkg::MMAD_TGT_RESERVED);
        chk(trap_o, 1'b1);
        chk(ext_launch_o, 1'b0);
        chk(trap_vector_o, 16'h009B);
        chk(dummy_rdata_o, 16'hFFFF);
        go(24'h07FFFF, 1'b1, mmad_pkg::MMAD_TGT_RESERVED);
        wr(4'h0, 16'h0004);
        go(24'h060000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        chk(trap_o, 1'b0);
        wr(4'h0, 16'h0014);
        $display("t_reserved done");
    endtask : t_reserved

    task automatic t_internal_dual_port_ram;
        go(24'h00F600, 1'b0, mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM);
        go(24'h00FDFF, 1'b1, mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM);
        go(24'h00F5FF, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        go(24'h00FE00, 1'b0, mmad_pkg::MMAD_TGT_SFR);
        go(24'h00F1FE, 1'b0, mmad_pkg::MMAD_TGT_SFR);
        go(24'h00FC01, 1'b1, mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM);
        chk({gpr_hit_o, gpr_byte_half_o, gpr_index_o}, 6'h30);
        go(24'h00FC1E, 1'b0, mmad_pkg::MMAD_TGT_INTERNAL_DUAL_PORT_RAM);
        chk({gpr_hit_o, gpr_byte_half_o, gpr_index_o}, 6'h2F);
        $display("t_internal_dual_port_ram done");
    endtask : t_internal_dual_port_ram

    task automatic t_xram;
        wr(4'h1, 16'h0000);
        wr(4'h6, 16'h00E0);
        go(24'h00E000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        chk(ext_bus_set_o, 3'h1);
        wr(4'h1, 16'h0004);
        go(24'h00E7FF, 1'b0, mmad_pkg::MMAD_TGT_XRAM_LOW);
        chk(route_wait_states_o, 2'h0);
        go(24'h00E000, 1'b1, mmad_pkg::MMAD_TGT_XRAM_LOW);
        go(24'h00E800, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        go(24'h090000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        wr(4'h1, 16'h000C);
        go(24'h090000, 1'b0, mmad_pkg::MMAD_TGT_XRAM_HIGH);
        go(24'h0FC004, 1'b1, mmad_pkg::MMAD_TGT_XRAM_HIGH);
        chk(route_offset_o, 24'h000004);
        go(24'h100000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        wr(4'h0, 16'h0010);
        go(24'h090000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        go(24'h00E000, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        wr(4'h0, 16'h0014);
        $display("t_xram done");
    endtask : t_xram

    task automatic t_can;
        wr(4'h1, 16'h0003);
        go(24'h00EF00, 1'b0, mmad_pkg::MMAD_TGT_CAN_A);
        chk(route_wait_states_o, 2'h2);
        go(24'h00EEFE, 1'b0, mmad_pkg::MMAD_TGT_CAN_B);
        go(24'h00EF00, 1'b1, mmad_pkg::MMAD_TGT_NONE);
        chk({width_error_o, ext_launch_o}, 2'h2);
        wr(4'h1, 16'h0002);
        go(24'h00EFFE, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        wr(4'h1, 16'h0000);
        go(24'h00EE00, 1'b0, mmad_pkg::MMAD_TGT_EXT);
        $display("t_can done");
    endtask : t_can

    // unmasked trap and ext events raise the interrupt; write-one clears
    task automatic t_irq;
        wr(4'h4, 16'h0007);
        wr(4'h5, 16'h0001);
        go(24'h050000, 1'b0, mmad_pkg::MMAD_TGT_RESERVED);
        @(posedge sys_clk_i);
        #1;
        chk(irq_o, 1'b1);
        rd(4'h4, 16'h0001);
        wr(4'h4, 16'h0001);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(irq_o, 1'b0);
        wr(4'h5, 16'h0004);
        go(24'h00EF00, 1'b1, mmad_pkg::MMAD_TGT_EXT);
        @(posedge sys_clk_i);
        #1;
        chk(irq_o, 1'b1);
        rd(4'h4, 16'h0004);
        $display("t_irq done");
    endtask : t_irq

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_flash();
        t_reserved();
        t_internal_dual_port_ram();
        t_xram();
        t_can();
        t_irq();
        wrap_up();
    end

    // tests need about 130 cycles; ample margin
    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule : mmad_decoder_tb
